// File: logic/sfsr_top.sv
// Fault status bank: live status, latched fault logs, masks, register port
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_map.svh"

module sfsr_top
  import sfsr_pkg::*;
(
  input wire logic CLK_I,                    // Device clock, 250 MHz
  input wire logic SYS_RST_I,                // Synchronous reset, high
  input wire logic CE_I,                     // Clock enable
  input wire logic [6:0] SUPPLY_FAULT_DETECTOR_I, // Detector outputs
  input wire logic WATCHDOG_INPUT_I,         // Watchdog timeout elapsed
  input wire logic [3:0] GENERAL_INPUT_I,    // General input levels
  input wire logic [8:0] PROGRAMMABLE_OUTPUT_I, // Output driven levels
  input wire logic [7:0] REG_ADDR_I,         // Register offset
  input wire logic REG_WR_I,                 // Write strobe
  input wire logic REG_RD_I,                 // Read strobe
  input wire logic [7:0] REG_WDATA_I,        // Write data
  output logic [7:0] REG_RDATA_O,            // Read data
  output logic REG_ACK_O,                    // Access done pulse
  output logic SUMMARY_FAULT_FLAG_O          // Summary fault flag level
);

  // ===========================================================
  // Submodules
  sfsr_status_t raw;
  sfsr_status_t live;
  sfsr_mask_t mask;
  sfsr_req_t req;

  assign raw = '{programmable_output: PROGRAMMABLE_OUTPUT_I, wdog: WATCHDOG_INPUT_I,
                 general_input: GENERAL_INPUT_I, supply_fault_detector: SUPPLY_FAULT_DETECTOR_I};
  assign req = '{addr: REG_ADDR_I, wr: REG_WR_I, rd: REG_RD_I,
                 wdata: REG_WDATA_I};

  sfsr_sampler u_sampler (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .raw_i(raw),
    .live_o(live)
  );

  sfsr_mask_bank u_masks (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .req_i(req),
    .mask_o(mask)
  );

  // ===========================================================
  // Functions
  function automatic logic [7:0] pad7(input logic [6:0] v);
    pad7 = {1'b0, v};
  endfunction

  function automatic logic [7:0] pad5(input logic [4:0] v);
    pad5 = {3'b000, v};
  endfunction

  // Live input/watchdog byte: watchdog in bit 4, inputs in 3..0
  function automatic logic [4:0] iw_of(input sfsr_status_t s);
    iw_of = {s.wdog, s.general_input};
  endfunction

  // Offsets of the two writable mask registers
  function automatic logic is_mask_ofs(input logic [7:0] a);
    is_mask_ofs = a == `SFSR_OFS_SUP_MASK || a == `SFSR_OFS_IW_MASK;
  endfunction

  // Offsets that return register contents on a read
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_mask_ofs(a) || (a >= `SFSR_OFS_SUP_STAT &&
                a <= `SFSR_OFS_OUT_HI);
  endfunction

  // ===========================================================
  // Change detection
  sfsr_state_t st;
  sfsr_state_t next_st;
  logic [6:0] chg_sup;
  logic [4:0] chg_iw;
  logic any_chg;
  logic clr;

  always_comb begin
    chg_sup = (live.supply_fault_detector ^ st.ref_sup) & ~mask.sup; // [R18] [R11] [R15]
    chg_iw = (iw_of(live) ^ st.ref_iw) & ~mask.iw; // [R18] [R16] [R15]
    any_chg = |{chg_sup, chg_iw}; // [R7]
    clr = req.rd && req.addr == `SFSR_OFS_IW_LOG &&
          st.mode == SFSR_FROZEN; // [R14]
  end

  // ===========================================================
  // Read multiplexer
  logic [7:0] rd_val;

  always_comb begin
    case (req.addr)
      `SFSR_OFS_SUP_MASK: rd_val = pad7(mask.sup); // [R11] [R17]
      `SFSR_OFS_IW_MASK: rd_val = pad5(mask.iw); // [R16] [R17]
      `SFSR_OFS_SUP_STAT: rd_val = pad7(live.supply_fault_detector); // [R1]
      `SFSR_OFS_IW_STAT: rd_val = pad5(iw_of(live)); // [R2] [R3]
      `SFSR_OFS_SUP_LOG: begin
        rd_val = pad7(st.log_sup & ~mask.sup); // [R8] [R15]
        rd_val[`SFSR_FLAG_BIT] = st.mode == SFSR_FROZEN; // [R7]
      end
      `SFSR_OFS_IW_LOG: rd_val = pad5(st.log_iw & ~mask.iw); // [R9] [R10]
      `SFSR_OFS_OUT_LO: rd_val = live.programmable_output[7:0]; // [R4]
      `SFSR_OFS_OUT_HI: rd_val = {7'h00, live.programmable_output[8]}; // [R5]
      default: rd_val = `SFSR_RST_BYTE;
    endcase
  end

  // ===========================================================
  // Logger and register port state
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    if (CE_I) begin
      next_st.ack = req.rd || req.wr;
      if (req.rd) begin
        next_st.rdata = rd_val;
      end
      case (st.mode)
        SFSR_ARMED: begin
          // Supply log tracks live state and input log tracks changes until a change freezes them
          next_st.log_sup = live.supply_fault_detector & ~mask.sup; // [R8] [R15]
          next_st.log_iw = chg_iw; // [R9] [R10]
          if (any_chg) begin
            next_st.mode = SFSR_FROZEN; // [R7]
          end
        end
        SFSR_FROZEN: begin
          // Contents held; only the input/watchdog log read releases [R13]
          if (clr) begin
            next_st.mode = SFSR_ARMED; // [R14]
            next_st.ref_sup = live.supply_fault_detector; // [R18]
            next_st.ref_iw = iw_of(live); // [R18]
            next_st.log_sup = `SFSR_RST_SUP;
            next_st.log_iw = `SFSR_RST_IW;
          end
        end
        default: begin
          next_st.mode = SFSR_ARMED;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st <= '{mode: SFSR_ARMED, ref_sup: `SFSR_RST_SUP,
              ref_iw: `SFSR_RST_IW, log_sup: `SFSR_RST_SUP,
              log_iw: `SFSR_RST_IW, rdata: `SFSR_RST_BYTE,
              ack: 1'b0}; // [R6]
    end else begin
      st <= next_st;
    end
  end

  // Writes reach only the mask bank; all other offsets drop them
  assign REG_RDATA_O = st.rdata; // [R17]
  assign REG_ACK_O = st.ack;
  assign SUMMARY_FAULT_FLAG_O = st.mode == SFSR_FROZEN; // [R7]

  // ===========================================================
  // Assertions
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  sequence rd_at(logic [7:0] a);
    CE_I && req.rd && req.addr == a;
  endsequence

  sequence frozen_hold;
    st.mode == SFSR_FROZEN && CE_I && !clr;
  endsequence

  sup_status_read_a: assert property ( // [R1]
    rd_at(`SFSR_OFS_SUP_STAT) |=> REG_RDATA_O == {1'b0, $past(live.supply_fault_detector)})
    else $error("supply status read wrong");

  wdog_status_read_a: assert property ( // [R2]
    rd_at(`SFSR_OFS_IW_STAT) |=>
      REG_RDATA_O[`SFSR_WDOG_BIT] == $past(live.wdog))
    else $error("watchdog status bit wrong");

  gpi_status_read_a: assert property ( // [R3]
    rd_at(`SFSR_OFS_IW_STAT) |=>
      REG_RDATA_O[3:0] == $past(live.general_input) && REG_RDATA_O[7:5] == 3'b000)
    else $error("input status bits wrong");

  out_low_read_a: assert property ( // [R4]
    rd_at(`SFSR_OFS_OUT_LO) |=> REG_RDATA_O == $past(live.programmable_output[7:0]))
    else $error("output status low wrong");

  out_high_read_a: assert property ( // [R5]
    rd_at(`SFSR_OFS_OUT_HI) |=> REG_RDATA_O == {7'h00, $past(live.programmable_output[8])})
    else $error("output status high wrong");

  reset_clear_a: assert property (disable iff (1'b0) // [R6]
    SYS_RST_I |=> st.mode == SFSR_ARMED && st.log_sup == 7'h00 &&
      st.log_iw == 5'h00 && mask == '0 && REG_RDATA_O == 8'h00)
    else $error("reset values not zero");

  sequence arm_change;
    st.mode == SFSR_ARMED && CE_I && any_chg;
  endsequence

  sequence frozen_rd_at(logic [7:0] a);
    rd_at(a) ##0 st.mode == SFSR_FROZEN;
  endsequence

  flag_set_a: assert property ( // [R7]
    arm_change |=> SUMMARY_FAULT_FLAG_O)
    else $error("summary flag not set on change");

  flag_read_a: assert property ( // [R7]
    rd_at(`SFSR_OFS_SUP_LOG) |=>
      REG_RDATA_O[`SFSR_FLAG_BIT] == $past(SUMMARY_FAULT_FLAG_O))
    else $error("summary flag reads wrong");

  log_freeze_a: assert property ( // [R13]
    frozen_hold |=> $stable(st.log_sup) && $stable(st.log_iw) &&
      st.mode == SFSR_FROZEN)
    else $error("fault logs moved while frozen");

  read_clears_a: assert property ( // [R14]
    CE_I && clr |=> !SUMMARY_FAULT_FLAG_O ##1
      (SUMMARY_FAULT_FLAG_O == $past(CE_I && any_chg)))
    else $error("log read did not clear flag");

  mask_zero_a: assert property ( // [R15]
    rd_at(`SFSR_OFS_IW_LOG) |=> (REG_RDATA_O[4:0] & $past(mask.iw)) == 5'h00)
    else $error("masked input log bit set");

  sup_mask_zero_a: assert property ( // [R11]
    rd_at(`SFSR_OFS_SUP_LOG) |=> (REG_RDATA_O[6:0] & $past(mask.sup)) == 7'h00)
    else $error("masked supply log bit set");

  mask_write_a: assert property ( // [R12]
    CE_I && req.wr && req.addr == `SFSR_OFS_IW_MASK |=>
      mask.iw == $past(req.wdata[4:0]))
    else $error("input mask not written");

  change_log_a: assert property ( // [R9]
    st.mode == SFSR_ARMED && CE_I && chg_iw != 5'h00 |=>
      st.log_iw == $past(chg_iw) && st.mode == SFSR_FROZEN)
    else $error("input change not logged");

  ack_pulse_a: assert property ( // [R17]
    CE_I && (req.rd || req.wr) |=> REG_ACK_O ##1 !REG_ACK_O || $past(req.rd
      || req.wr) && $past(CE_I))
    else $error("access not acknowledged");

  sup_log_take_a: assert property ( // [R8]
    arm_change |=> st.log_sup == $past(live.supply_fault_detector & ~mask.sup))
    else $error("supply log not taken at freeze");

  wdog_log_a: assert property ( // [R10]
    st.mode == SFSR_ARMED && CE_I && !mask.iw[4] &&
      live.wdog != st.ref_iw[4] |=> st.log_iw[4] && SUMMARY_FAULT_FLAG_O)
    else $error("watchdog change not logged");

  gpi_quiet_a: assert property ( // [R9]
    arm_change ##0 live.general_input == st.ref_iw[3:0] |=> st.log_iw[3:0] == 4'h0)
    else $error("unchanged input logged");

  ref_hold_a: assert property ( // [R13]
    frozen_hold |=> $stable(st.ref_sup) && $stable(st.ref_iw))
    else $error("reference moved while frozen");

  flag_bit_a: assert property ( // [R7]
    frozen_rd_at(`SFSR_OFS_SUP_LOG) |=> REG_RDATA_O[`SFSR_FLAG_BIT])
    else $error("frozen supply log read lost flag");

  first_read_a: assert property ( // [R14]
    frozen_rd_at(`SFSR_OFS_SUP_LOG) |=> SUMMARY_FAULT_FLAG_O)
    else $error("supply log read cleared flag");

  armed_read_a: assert property ( // [R14]
    rd_at(`SFSR_OFS_IW_LOG) ##0 st.mode == SFSR_ARMED |=>
      $stable(st.ref_sup) && $stable(st.ref_iw))
    else $error("armed log read moved reference");

  all_masked_a: assert property ( // [R15]
    st.mode == SFSR_ARMED && CE_I && &mask.sup && &mask.iw |=>
      !SUMMARY_FAULT_FLAG_O)
    else $error("fully masked change froze logs");

  sup_mask_write_a: assert property ( // [R11]
    CE_I && req.wr && req.addr == `SFSR_OFS_SUP_MASK |=>
      mask.sup == $past(req.wdata[6:0]))
    else $error("supply mask not written");

  sup_mask_read_a: assert property ( // [R11]
    rd_at(`SFSR_OFS_SUP_MASK) |=> REG_RDATA_O == {1'b0, $past(mask.sup)})
    else $error("supply mask reads wrong");

  iw_mask_read_a: assert property ( // [R16]
    rd_at(`SFSR_OFS_IW_MASK) |=> REG_RDATA_O == {3'b000, $past(mask.iw)})
    else $error("input mask reads wrong");

  ro_write_a: assert property ( // [R17]
    CE_I && req.wr && !is_mask_ofs(req.addr) |=> $stable(mask))
    else $error("read-only write changed a mask");

  unmapped_read_a: assert property ( // [R17]
    CE_I && req.rd && !is_mapped(req.addr) |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  iw_log_rsvd_a: assert property ( // [R10]
    rd_at(`SFSR_OFS_IW_LOG) |=> REG_RDATA_O[7:5] == 3'b000)
    else $error("input log reserved bits set");

  sample_a: assert property ( // [R18]
    CE_I |=> live == $past(raw))
    else $error("live levels not sampled");

  ce_hold_a: assert property ( // [R18]
    !CE_I |=> $stable(live) && $stable(mask) && $stable(st.mode) &&
      !REG_ACK_O)
    else $error("state moved while disabled");

  clear_ref_a: assert property ( // [R18]
    CE_I && clr |=> st.ref_sup == $past(live.supply_fault_detector) &&
      st.ref_iw == $past(iw_of(live)))
    else $error("reference not taken at clear");

  reset_state_a: assert property (disable iff (1'b0) // [R6]
    SYS_RST_I |=> live == '0 && st.ref_sup == 7'h00 &&
      st.ref_iw == 5'h00 && !REG_ACK_O)
    else $error("reset state not zero");

  ack_idle_a: assert property (
    !(CE_I && (req.rd || req.wr)) |=> !REG_ACK_O)
    else $error("ack without access");

  rdata_hold_a: assert property (
    !(CE_I && req.rd) |=> $stable(REG_RDATA_O))
    else $error("read data moved without read");

endmodule
`default_nettype wire

// File: logic/sfsr_map.svh
// Register offsets, field positions and reset values of the fault status bank
//
// Function
// R1 - Supply fault status bits 0..6 show live detector faults; bit 7 reserved.
// R2 - Input/watchdog status bit 4 is high while watchdog timeout has elapsed.
// R3 - Input/watchdog status bits 0..3 show general inputs 1..4; bits 7..5 zero.
// R4 - Output status low bits 0..7 show programmable outputs 1..8.
// R5 - Output status high bit 0 shows programmable output 9; rest reserved.
// R6 - All status, fault log and mask registers reset to zero.
// R7 - Summary flag, supply log bit 7, sets on any logged change.
// R8 - Supply log bits 0..6 record faults on the seven supplies.
// R9 - Input log bits 0..3 set when general inputs changed since last read.
// R10 - Input log bit 4 set when watchdog level changed; bits 7..5 zero.
// R11 - Read/write supply mask; set bit stops logging that supply; bit 7 unused.
// R12 - Second mask register covers general inputs and watchdog logging.
// R13 - Once summary flag is high, both fault logs freeze until read.
// R14 - Reading the input/watchdog log clears summary flag; host reads it last.
// R15 - Set mask bit holds log bit at zero; summary flag unmaskable.
// R16 - Second mask: bit 4 watchdog, bits 0..3 general inputs, 7..5 unused.
// R17 - Reserved bits read zero; writes to read-only registers are ignored.
// R18 - Live sources sampled each cycle, compared against values at last read.
`ifndef SFSR_MAP_SVH
`define SFSR_MAP_SVH

// ===========================================================
// Register offsets
`define SFSR_OFS_SUP_MASK 8'h9d
`define SFSR_OFS_IW_MASK 8'h9e
`define SFSR_OFS_SUP_STAT 8'hda
`define SFSR_OFS_IW_STAT 8'hdb
`define SFSR_OFS_SUP_LOG 8'hdc
`define SFSR_OFS_IW_LOG 8'hdd
`define SFSR_OFS_OUT_LO 8'hde
`define SFSR_OFS_OUT_HI 8'hdf

// ===========================================================
// Field positions
`define SFSR_FLAG_BIT 7
`define SFSR_WDOG_BIT 4

// ===========================================================
// Reset values
`define SFSR_RST_BYTE 8'h00
`define SFSR_RST_SUP 7'h00
`define SFSR_RST_IW 5'h00
`define SFSR_RST_OUT 9'h000

`endif

// File: logic/sfsr_pkg.sv
// Types shared by the fault status bank modules
package sfsr_pkg;

  // Live monitored levels as sampled each enabled cycle
  typedef struct packed {
    logic [8:0] programmable_output;
    logic wdog;
    logic [3:0] general_input;
    logic [6:0] supply_fault_detector;
  } sfsr_status_t;

  // Both mask registers
  typedef struct packed {
    logic [4:0] iw;
    logic [6:0] sup;
  } sfsr_mask_t;

  // Register access request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfsr_req_t;

  typedef enum logic [1:0] {
    SFSR_ARMED = 2'b01,
    SFSR_FROZEN = 2'b10
  } sfsr_log_e;

  // Logger state
  typedef struct packed {
    sfsr_log_e mode;
    logic [6:0] ref_sup;
    logic [4:0] ref_iw;
    logic [6:0] log_sup;
    logic [4:0] log_iw;
    logic [7:0] rdata;
    logic ack;
  } sfsr_state_t;

endpackage

// File: logic/sfsr_sampler.sv
// Samples the live monitored levels once per enabled cycle
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_map.svh"

module sfsr_sampler
  import sfsr_pkg::*;
(
  input wire logic clk_i,             // Device clock
  input wire logic rst_i,             // Synchronous reset
  input wire logic ce_i,              // Clock enable
  input wire sfsr_status_t raw_i,     // Raw live levels
  output sfsr_status_t live_o         // Registered live levels
);

  sfsr_status_t st;
  sfsr_status_t next_st;

  always_comb begin
    next_st = st;
    if (ce_i) begin
      next_st = raw_i; // [R18]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{programmable_output: `SFSR_RST_OUT, wdog: 1'b0, general_input: 4'h0,
              supply_fault_detector: `SFSR_RST_SUP}; // [R6]
    end else begin
      st <= next_st;
    end
  end

  assign live_o = st;

endmodule
`default_nettype wire

// File: logic/sfsr_mask_bank.sv
// The two read/write error mask registers
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_map.svh"

module sfsr_mask_bank
  import sfsr_pkg::*;
(
  input wire logic clk_i,             // Device clock
  input wire logic rst_i,             // Synchronous reset
  input wire logic ce_i,              // Clock enable
  input wire sfsr_req_t req_i,        // Register access request
  output sfsr_mask_t mask_o           // Current masks
);

  sfsr_mask_t st;
  sfsr_mask_t next_st;

  always_comb begin
    next_st = st;
    if (ce_i && req_i.wr) begin
      if (req_i.addr == `SFSR_OFS_SUP_MASK) begin
        next_st.sup = req_i.wdata[6:0]; // [R11]
      end
      if (req_i.addr == `SFSR_OFS_IW_MASK) begin
        next_st.iw = req_i.wdata[4:0]; // [R12] [R16]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{iw: `SFSR_RST_IW, sup: `SFSR_RST_SUP}; // [R6]
    end else begin
      st <= next_st;
    end
  end

  assign mask_o = st;

endmodule
`default_nettype wire

// File: testbench/sfsr_host.sv
// Host model: byte access to the register port of the fault status bank
`timescale 1ns/1ps
`default_nettype none
module sfsr_host (
  input wire logic clk_i,            // Device clock
  input wire logic ack_i,            // Access done pulse
  input wire logic [7:0] rdata_i,    // Read data
  output logic [7:0] addr_o,         // Register offset
  output logic wr_o,                 // Write strobe
  output logic rd_o,                 // Read strobe
  output logic [7:0] wdata_o         // Write data
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // ========
  // One-cycle strobe, answer taken one edge after it
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic k);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released lines show a changed pattern, not the last value
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
    k = ack_i;
  endtask
endmodule
`default_nettype wire

// File: testbench/supervisor_fault_status_registers_tb.sv
// Testbench: fault status bank against a cycle model of its registers
`timescale 1ns/1ps
`default_nettype none
module supervisor_fault_status_registers_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] supply_fault_detector = 7'h00;
  logic wd = 1'b0;
  logic [3:0] general_input = 4'h0;
  logic [8:0] programmable_output = 9'h000;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, ack, flag;
  logic ce = 1'b1;
  int x_ak;
  int n_fail = 0;
  int checked = 0;
  int lv_s, lv_i, lv_p, rf_s, rf_i, lg_s, lg_i, mk_s, mk_i, frz, x_rd, x_mk;
  logic [31:0] rnd = 32'h00000046;
  logic [7:0] offs [11] = '{8'h9d, 8'h9e, 8'hda, 8'hdb, 8'hdc, 8'hdd,
                            8'hde, 8'hdf, 8'h00, 8'hd8, 8'hff};
  logic [7:0] stat [4] = '{8'hda, 8'hdb, 8'hde, 8'hdf};

  always #2 clk = ~clk;

  sfsr_top dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce),
    .SUPPLY_FAULT_DETECTOR_I(supply_fault_detector), .WATCHDOG_INPUT_I(wd),
    .GENERAL_INPUT_I(general_input), .PROGRAMMABLE_OUTPUT_I(programmable_output),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .REG_ACK_O(ack), .SUMMARY_FAULT_FLAG_O(flag));

  sfsr_host host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  // ========
  // Cycle model: one-cycle sampler, freezing logger, masks
  always @(posedge clk) begin
    x_ak = !rst && ce && (rd || wr);
    if (rst) begin
      {lv_s, lv_i, lv_p, rf_s, rf_i, lg_s, lg_i, mk_s, mk_i, frz} = 320'h0;
    end else if (ce) begin
      if (rd) begin
        x_mk = 255;
        case (addr)
          8'h9d: x_rd = mk_s;
          8'h9e: x_rd = mk_i;
          8'hda: x_rd = lv_s;
          8'hdb: x_rd = lv_i;
          8'hdc: x_rd = frz * 128 + (lg_s & ~mk_s);
          8'hdd: x_rd = lg_i & ~mk_i;
          8'hde: x_rd = lv_p & 255;
          8'hdf: x_rd = lv_p >> 8;
          default: x_rd = 0;
        endcase
        // Log contents while armed are left open; only the flag bit counts
        if (!frz && addr inside {8'hdc, 8'hdd}) x_mk = 128;
      end
      if (rd && addr == 8'hdd && frz) begin
        frz = 0;
        rf_s = lv_s;
        rf_i = lv_i;
      end else if (!frz && ((lv_s ^ rf_s) & ~mk_s || (lv_i ^ rf_i) & ~mk_i))
      begin
        frz = 1;
        lg_s = lv_s & ~mk_s;
        lg_i = (lv_i ^ rf_i) & ~mk_i;
      end
      if (wr && addr == 8'h9d) mk_s = wdata & 127;
      if (wr && addr == 8'h9e) mk_i = wdata & 31;
      lv_s = supply_fault_detector;
      lv_i = {wd, general_input};
      lv_p = programmable_output;
    end
  end

  always @(negedge clk) if (!rst) chk("flag", frz, {7'h00, flag}, 1);

  // ========
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input int x, input logic [7:0] g,
                     input int mk);
    checked++;
    if ((g & mk[7:0]) !== (x[7:0] & mk[7:0])) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x[7:0], g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, output logic [7:0] q);
    logic k;
    host.access(1'b0, a, 8'h00, q, k);
    chk("ack", x_ak, {7'h00, k}, 255);
    chk("rdata", x_rd, q, x_mk);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    host.access(1'b1, a, d, q, k);
    chk("ack", x_ak, {7'h00, k}, 255);
  endtask

  task automatic drive(input logic [20:0] v);
    @(posedge clk);
    #1;
    {programmable_output, wd, general_input, supply_fault_detector} = v;
    repeat (3) @(posedge clk);
  endtask

  task automatic service();
    logic [7:0] q;
    rd_chk(8'hdc, q);
    if (q[7] === 1'b1) rd_chk(8'hdd, q);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ========
  // Main sequence
  initial begin
    logic [7:0] q;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (offs[i]) rd_chk(offs[i], q);
    $display("reset values done");
    foreach (offs[i]) wr_chk(offs[i], 8'hff);
    foreach (offs[i]) rd_chk(offs[i], q);
    wr_chk(8'h9d, 8'h00);
    wr_chk(8'h9e, 8'h00);
    $display("register access done");
    repeat (24) begin
      repeat (21) rnd = lfsr(rnd);
      drive(rnd[20:0]);
      drive(rnd[31:11]);
      foreach (stat[i]) rd_chk(stat[i], q);
      service();
    end
    $display("status and log test done");
    drive(21'h0000ff);
    wr_chk(8'h9d, 8'h55);
    service();
    drive(21'h000000);
    service();
    wr_chk(8'h9d, 8'h7f);
    wr_chk(8'h9e, 8'h1f);
    repeat (8) begin
      repeat (21) rnd = lfsr(rnd);
      drive(rnd[20:0]);
      service();
    end
    drive(21'h000000);
    wr_chk(8'h9d, 8'h00);
    wr_chk(8'h9e, 8'h00);
    drive(21'h000080);
    service();
    $display("mask test done");
    ce = 1'b0;
    drive(21'h1fffff);
    wr_chk(8'h9d, 8'h7f);
    rd_chk(8'hdc, q);
    ce = 1'b1;
    drive(21'h000000);
    service();
    $display("clock enable test done");
    complete_run();
  end

  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
